/* File: rtl/gscr_pkg.sv */
// Purpose: shared constants and types for the global serial control register bank
// Assumes: 8-bit register address, 16-bit data, serial port already deserialised
// Notes:   converter registers hold field layouts only
package gscr_pkg;

  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 16;

  typedef logic [ADDR_W-1:0] gscr_addr_t;
  typedef logic [DATA_W-1:0] gscr_data_t;

  // Register offsets
  localparam gscr_addr_t GLOBAL_CONTROL_WORD            = 8'h00;
  localparam gscr_addr_t CONVERTER_POWER_LVDS_CTRL      = 8'h01;
  localparam gscr_addr_t TEST_PATTERN_LATENCY_CTRL      = 8'h02;
  localparam gscr_addr_t SERIAL_RATE_DIGITAL_GAIN_CTRL  = 8'h03;
  localparam gscr_addr_t OFFSET_REMOVAL_PRBS_RES_CTRL   = 8'h04;
  localparam gscr_addr_t USER_TEST_PATTERN              = 8'h05;
  localparam gscr_addr_t OFFSET_READBACK_SELECT_CHOPPER = 8'h07;
  localparam gscr_addr_t OFFSET_REMOVAL_READBACK_VALUE  = 8'h08;
  localparam gscr_addr_t DITHER_ENABLE_CTRL             = 8'h0b;
  localparam gscr_addr_t CH1_GAIN_OFFSET                = 8'h0d;
  localparam gscr_addr_t CH1_OFFSET_EXT                 = 8'h0e;
  localparam gscr_addr_t CH2_GAIN_OFFSET                = 8'h0f;
  localparam gscr_addr_t CH2_OFFSET_EXT                 = 8'h10;
  localparam gscr_addr_t CH3_GAIN_OFFSET                = 8'h11;

  // Address windows of the dies
  localparam gscr_addr_t CONV_FIRST = 8'h01;
  localparam gscr_addr_t CONV_LAST  = 8'h3c;
  localparam gscr_addr_t AMP_FIRST  = 8'hc0;
  localparam gscr_addr_t AMP_LAST   = 8'hcd;

  // Global control word fields, zero word and readback mask
  localparam int unsigned SOFT_RESET_BIT = 0;
  localparam int unsigned READBACK_BIT   = 1;
  localparam int unsigned ADDR_SPLIT_BIT = 2;
  localparam gscr_data_t  ZERO_WORD      = 16'h0000;
  localparam gscr_data_t  READBACK_MASK  = 16'h3fff;

  localparam int unsigned NUM_CONV = 14;

  typedef struct packed {
    logic       wr;
    gscr_addr_t addr;
    gscr_data_t data;
  } gscr_wr_s;

  typedef struct packed {
    logic addr_split;
    logic readback_en;
    logic soft_reset;
  } gscr_ctrl_s;

endpackage

/* File: rtl/gscr_ctrl_word.sv */
// Purpose: write-only global control word with self-clearing soft reset
// Assumes: one write strobe per serial word
// Notes:   soft reset lasts exactly one clock
`timescale 1ns/1ps
`default_nettype none
module gscr_ctrl_word
  import gscr_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst_b,
  input  wire logic       wr_en,
  input  wire gscr_data_t wr_data,
  output gscr_ctrl_s      ctrl
);

  gscr_ctrl_s next_ctrl;

  always_comb begin
    next_ctrl            = ctrl;
    next_ctrl.soft_reset = 1'b0; // R5
    if (wr_en) begin
      next_ctrl.addr_split  = wr_data[ADDR_SPLIT_BIT]; // R1
      next_ctrl.readback_en = wr_data[READBACK_BIT]; // R3
      next_ctrl.soft_reset  = wr_data[SOFT_RESET_BIT]; // R4
    end
  end

  // Soft reset clears the split and readback bits too
  always_ff @(posedge clk) begin
    if (!rst_b || ctrl.soft_reset) begin
      ctrl <= '0; // R6
    end else begin
      ctrl <= next_ctrl;
    end
  end

endmodule
`default_nettype wire

/* File: rtl/gscr_top.sv */
// Purpose: global control register and converter register bank of the serial port
// Assumes: serial shifter outside delivers whole words as one-cycle strobes
// Notes:   readback data valid the cycle after rd_en when readout enabled
// Contract
// R1 - Split bit separates amplifier die address spaces
// R2 - Host sets split only for 213-217
// R3 - Readback bit enables readout, else write-only
// R4 - Soft reset bit returns device to reset
// R5 - Soft reset bit clears itself
// R6 - Global fields write-only, reset to zero
// R7 - Converter decodes addresses 1 through 60
// R8 - Amplifier dies share addresses 192-205 by default
// R9 - Reset pin clears all registers to zero
// R10 - Host writes zero to undefined bits
`timescale 1ns/1ps
`default_nettype none
module gscr_top
  import gscr_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst_b,
  input  wire gscr_wr_s   wr,
  input  wire logic       rd_en,
  input  wire gscr_addr_t rd_addr,
  input  wire gscr_data_t offset_readback_in,
  output gscr_data_t      rd_data,
  output logic            rd_valid,
  output logic            amp_die1_wr,
  output logic            amp_die2_wr,
  output gscr_addr_t      amp_addr,
  output gscr_data_t      amp_data,
  output logic            soft_reset_pulse,
  output gscr_ctrl_s      ctrl_state
);

  gscr_ctrl_s ctrl;
  gscr_data_t conv_regs [NUM_CONV];

  // One slot per converter register; the last slot is a filler never written
  localparam gscr_addr_t CONV_ADDR [NUM_CONV] = '{
    CONVERTER_POWER_LVDS_CTRL,
    TEST_PATTERN_LATENCY_CTRL,
    SERIAL_RATE_DIGITAL_GAIN_CTRL,
    OFFSET_REMOVAL_PRBS_RES_CTRL,
    USER_TEST_PATTERN,
    OFFSET_READBACK_SELECT_CHOPPER,
    OFFSET_REMOVAL_READBACK_VALUE,
    DITHER_ENABLE_CTRL,
    CH1_GAIN_OFFSET,
    CH1_OFFSET_EXT,
    CH2_GAIN_OFFSET,
    CH2_OFFSET_EXT,
    CH3_GAIN_OFFSET,
    GLOBAL_CONTROL_WORD
  };

  function automatic logic in_conv(input gscr_addr_t a);
    return (a >= CONV_FIRST) && (a <= CONV_LAST); // R7
  endfunction

  function automatic logic in_amp(input gscr_addr_t a);
    return (a >= AMP_FIRST) && (a <= AMP_LAST); // R8
  endfunction

  // Filler slot holds no register; the control word reads as zero
  function automatic logic is_filler(input gscr_addr_t a);
    return a == GLOBAL_CONTROL_WORD; // R6
  endfunction

  // Write decode of the incoming word
  wire logic wr_strobe = wr.wr;
  wire logic glob_wr   = wr_strobe && (wr.addr == GLOBAL_CONTROL_WORD);
  wire logic conv_wr   = wr_strobe && in_conv(wr.addr); // R7
  wire logic amp_base  = in_amp(wr.addr);
  wire logic amp_upper = wr.addr > AMP_LAST;
  // Soft reset clears like the pin, one clock after its write
  wire logic clear_all = !rst_b || ctrl.soft_reset; // R9 R4

  gscr_ctrl_word u_ctrl (
    .clk     (clk),
    .rst_b   (rst_b),
    .wr_en   (glob_wr),
    .wr_data (wr.data),
    .ctrl    (ctrl)
  );

  assign soft_reset_pulse = ctrl.soft_reset;
  assign ctrl_state       = ctrl;

  // Live slot follows its input, masked by READBACK_MASK, every clock except while cleared, and ignores host writes
  genvar g;
  generate
    for (g = 0; g < NUM_CONV; g++) begin : g_reg
      if (CONV_ADDR[g] == OFFSET_REMOVAL_READBACK_VALUE) begin : g_live
        always_ff @(posedge clk) begin
          if (clear_all) begin
            conv_regs[g] <= ZERO_WORD; // R9
          end else begin
            conv_regs[g] <= offset_readback_in & READBACK_MASK;
          end
        end
      end else begin : g_host
        wire logic hit_w = conv_wr && (wr.addr == CONV_ADDR[g]) && !is_filler(CONV_ADDR[g]);
        always_ff @(posedge clk) begin
          if (clear_all) begin
            conv_regs[g] <= ZERO_WORD; // R9
          end else if (hit_w) begin
            conv_regs[g] <= wr.data;
          end
        end
      end
    end
  endgenerate

  // Read select as an OR chain; slot addresses are unique, so one hit at most
  wire gscr_data_t rd_chain [NUM_CONV+1];
  assign rd_chain[0] = ZERO_WORD;
  generate
    for (g = 0; g < NUM_CONV; g++) begin : g_rd
      wire logic       hit_r = (rd_addr == CONV_ADDR[g]) && !is_filler(CONV_ADDR[g]);
      wire gscr_data_t pick  = hit_r ? conv_regs[g] : ZERO_WORD;
      assign rd_chain[g+1] = rd_chain[g] | pick;
    end
  endgenerate
  wire gscr_data_t sel_data = rd_chain[NUM_CONV];

  // Shared map hits both dies until split; the split then hands die 2 only everything above it
  wire logic next_die1 = wr_strobe && amp_base; // R8
  wire logic next_die2 = wr_strobe && (ctrl.addr_split ? amp_upper : amp_base); // R1

  always_ff @(posedge clk) begin
    if (clear_all) begin
      amp_die1_wr <= 1'b0;
    end else begin
      amp_die1_wr <= next_die1;
    end
  end

  always_ff @(posedge clk) begin
    if (clear_all) begin
      amp_die2_wr <= 1'b0;
    end else begin
      amp_die2_wr <= next_die2;
    end
  end

  always_ff @(posedge clk) begin
    if (clear_all) begin
      amp_addr <= '0;
    end else begin
      amp_addr <= wr.addr;
    end
  end

  always_ff @(posedge clk) begin
    if (clear_all) begin
      amp_data <= ZERO_WORD;
    end else begin
      amp_data <= wr.data;
    end
  end

  // Reads while readout is off get no answer at all
  wire logic       rd_ok        = rd_en && ctrl.readback_en; // R3
  wire gscr_data_t next_rd_data = rd_ok ? sel_data : ZERO_WORD;

  always_ff @(posedge clk) begin
    if (clear_all) begin
      rd_valid <= 1'b0;
    end else begin
      rd_valid <= rd_ok;
    end
  end

  always_ff @(posedge clk) begin
    if (clear_all) begin
      rd_data <= ZERO_WORD;
    end else begin
      rd_data <= next_rd_data;
    end
  end

endmodule
`default_nettype wire

/* File: test/gscr_top_assertions.sv */
// Purpose: port checks of gscr_top
// Assumes: one-cycle strobes
// Notes:   requests in the soft reset cycle are lost
`timescale 1ns/1ps
`default_nettype none
module gscr_chk
  import gscr_pkg::*;
(
  input wire logic       clk,
  input wire logic       rst_b,
  input wire gscr_wr_s   wr,
  input wire logic       rd_en,
  input wire gscr_addr_t rd_addr,
  input wire gscr_data_t rd_data,
  input wire logic       rd_valid,
  input wire logic       amp_die1_wr,
  input wire logic       amp_die2_wr,
  input wire logic       soft_reset_pulse,
  input wire gscr_ctrl_s ctrl_state
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  wire q = wr.wr && !soft_reset_pulse;
  wire g = q && wr.addr == GLOBAL_CONTROL_WORD;
  property p_sr; g && wr.data[SOFT_RESET_BIT] |=> soft_reset_pulse ##1 !soft_reset_pulse && ctrl_state == 3'h0;
  endproperty
  a_sr: assert property (p_sr) else $error("soft reset wrong");
  property p_nsr; g && !wr.data[SOFT_RESET_BIT] |=> !soft_reset_pulse && ctrl_state.readback_en == $past(wr.data[1]);
  endproperty
  a_nsr: assert property (p_nsr) else $error("control write wrong");
  property p_rbon; rd_en && ctrl_state.readback_en && !soft_reset_pulse |=> rd_valid; endproperty
  a_rbon: assert property (p_rbon) else $error("read not answered");
  property p_rboff; !(rd_en && ctrl_state.readback_en) |=> !rd_valid; endproperty
  a_rboff: assert property (p_rboff) else $error("read answered in write-only mode");
  property p_wo; rd_en && rd_addr == GLOBAL_CONTROL_WORD |=> rd_data == ZERO_WORD; endproperty
  a_wo: assert property (p_wo) else $error("control word readable");
  property p_sh; q && !ctrl_state.addr_split && wr.addr inside {[AMP_FIRST:AMP_LAST]} |=> amp_die1_wr && amp_die2_wr;
  endproperty
  a_sh: assert property (p_sh) else $error("shared write missed a die");
  property p_sp; q && ctrl_state.addr_split && wr.addr > AMP_LAST |=> amp_die2_wr && !amp_die1_wr; endproperty
  a_sp: assert property (p_sp) else $error("split write wrong die");
  property p_cv; wr.wr && wr.addr inside {[CONV_FIRST:CONV_LAST]} |=> !amp_die1_wr && !amp_die2_wr; endproperty
  a_cv: assert property (p_cv) else $error("converter write leaked");
  property p_hr; $rose(rst_b) |-> ctrl_state == 3'h0 && !rd_valid && !soft_reset_pulse; endproperty
  a_hr: assert property (p_hr) else $error("reset left state");
  c_sr: cover property (soft_reset_pulse);
  c_sp: cover property (amp_die2_wr && !amp_die1_wr);
  c_rd: cover property (rd_valid);
endmodule
bind gscr_top gscr_chk u_chk (.clk, .rst_b, .wr, .rd_en, .rd_addr, .rd_data, .rd_valid,
  .amp_die1_wr, .amp_die2_wr, .soft_reset_pulse, .ctrl_state);
`default_nettype wire

/* File: test/gscr_host.sv */
// Purpose: serial host handing whole words
// Assumes: one word per strobe
// Notes:   changes only on falling edges
`timescale 1ns/1ps
`default_nettype none
module gscr_host
  import gscr_pkg::*;
(
  input  wire logic   clk,
  output var gscr_wr_s wr
);
  initial wr = '0;
  task automatic send(input gscr_addr_t a, input gscr_data_t d);
    @(negedge clk);
    wr = '{1'b1, a, d};
    @(negedge clk);
    wr = '0;
  endtask
endmodule
`default_nettype wire

/* File: test/tb.sv */
// Purpose: self-checking bench of gscr_top
// Assumes: model checked at every result
// Notes:   also writes live register 8, unmapped addresses 3d and ce, and die 2 split address d5
`timescale 1ns/1ps
`default_nettype none
module tb;
  import gscr_pkg::*;
  logic clk = 0, rst_b = 0, rd_en = 0, rd_valid, d1, d2, srp;
  gscr_addr_t rd_addr = '0, amp_addr;
  gscr_data_t offs = '0, rd_data, amp_data;
  gscr_wr_s wr;
  gscr_ctrl_s ctrl;
  int n_fail = 0, cmp_count = 0, cyc = 0, m[256];
  int ra[6] = '{2, 3, 4, 5, 7, 11};
  int mk[6] = '{'hffff, 'hf700, 'hfff3, 'hffff, 'hf801, 'h0800};
  bit rb, sp;
  gscr_host host (.clk(clk), .wr(wr));
  gscr_top dut (.clk(clk), .rst_b(rst_b), .wr(wr), .rd_en(rd_en), .rd_addr(rd_addr),
    .offset_readback_in(offs), .rd_data(rd_data), .rd_valid(rd_valid), .amp_die1_wr(d1), .amp_die2_wr(d2),
    .amp_addr(amp_addr), .amp_data(amp_data), .soft_reset_pulse(srp), .ctrl_state(ctrl));
  initial forever #10 clk = ~clk;
  always @(posedge clk) if (++cyc > 2000) begin n_fail++; final_report(); end
  task automatic chk(input gscr_data_t got, input gscr_data_t exp);
    cmp_count++;
    if (got !== exp) begin n_fail++; $display("[ERR] %0t got %h exp %h", $time, got, exp); end
  endtask
  task automatic wo(input int a, input int d);
    bit h1 = a inside {[AMP_FIRST:AMP_LAST]};
    bit h2 = sp ? a > AMP_LAST : h1;
    host.send(gscr_addr_t'(a), gscr_data_t'(d));
    chk({d1, d2, srp}, {h1, h2, a == 0 && d[0]});
    if (h1 || h2) chk(amp_data, gscr_data_t'(d));
    if (h1 || h2) chk(amp_addr, gscr_data_t'(a));
    if (a == 0 && d[0]) begin m = '{default: 0}; rb = 0; sp = 0; @(negedge clk); end
    else if (a == 0) begin rb = d[1]; sp = d[2]; end
    else if (a inside {ra}) m[a] = d;
    chk(ctrl, {sp, rb, 1'b0});
  endtask
  task automatic rd(input int a);
    @(negedge clk); rd_en = 1; rd_addr = gscr_addr_t'(a);
    @(negedge clk); rd_en = 0;
    chk(rd_valid, rb);
    chk(rd_data, !rb ? ZERO_WORD : a == 8 ? offs & READBACK_MASK : gscr_data_t'(m[a]));
  endtask
  task automatic final_report();
    $display("fails %0d compares %0d", n_fail, cmp_count);
    if (n_fail == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    void'($urandom(7133));
    offs = gscr_data_t'($urandom);
    repeat (8) @(negedge clk);
    rst_b = 1;
    rd(2); wo(0, 'h2);
    foreach (ra[i]) wo(ra[i], $urandom & mk[i]);
    foreach (ra[i]) rd(ra[i]);
    wo(8, 'h1234); wo('h3d, 'h1); wo('hc5, $urandom); wo('hce, 'h3);
    rd(8); rd('h3d); rd(0); rd('hc5);
    wo(0, 'h6); wo('hd5, $urandom); wo(0, 'h2); wo('hc0, 'h5);
    wo(0, 'h1); rd(2); wo(0, 'h2); rd(3);
    wo(4, 'h0013); @(negedge clk) rst_b = 0;
    @(negedge clk) rst_b = 1;
    m = '{default: 0}; rb = 0; sp = 0;
    wo(0, 'h2); rd(4);
    final_report();
  end
endmodule
`default_nettype wire
